/* hw/rhbpc_pin_control.sv */
// Bus pin state control for reset, bus-yield grant, backoff and emulation.

`timescale 1ns/1ps
`include "rhbpc_defs.svh"

module rhbpc_pin_control (
  input wire logic clk,
  input wire logic resetn,
  // Pins from the shared bus, not yet on this clock.
  input wire logic yieldReqPin,
  input wire logic busBackoffPinN,
  input wire logic emulationFloatSelectN,
  // Core-side levels, already on this clock.
  input wire logic busCycleActive,
  input wire logic coreBusReq,
  input wire logic selftestFailed,
  input wire logic [3:0] tcOutputMode,
  input wire logic [3:0] tcOutValue,
  // Grant to the other master and permission for the core.
  output logic busYieldGrant,
  output logic accessAllowed,
  // Enables; a low enable lets its pin group float.
  output logic addrDataOe,
  output logic ctrlOe,
  // Levels for the control pins, active-low ones marked N.
  output logic [3:0] byteLaneEnablesN,
  output logic addressStrobeN,
  output logic stallN,
  output logic dataTransferEnableN,
  output logic lockN,
  output logic writeReadSel,
  output logic transferDirection,
  output logic burstLastN,
  // Request, error and acknowledge pins keep driving while the bus is yielded; select floats.
  output logic busRequestOut,
  output logic busRequestOe,
  output logic selectOe,
  output logic selftestErrorN,
  output logic [3:0] dmaAcknowledgeN,
  // Terminal-count pins, one enable and one value per pin.
  output logic [3:0] endProcessTcOe,
  output logic [3:0] endProcessTcOut
);

  // ============================================================
  // Pin synchronisers
  // Only the second flop of each pair is read; backoff and select are
  // inverted on entry so that every flop pair holds an active-high level.
  logic [1:0] yieldSync_q;
  logic [1:0] boffSync_q;
  logic [1:0] onceSync_q;
  always_ff @(posedge clk) begin
    yieldSync_q <= {yieldSync_q[0], yieldReqPin};
    boffSync_q <= {boffSync_q[0], ~busBackoffPinN};
    onceSync_q <= {onceSync_q[0], ~emulationFloatSelectN};
  end
  wire logic yieldReq = yieldSync_q[1];
  wire logic backoff = boffSync_q[1];
  wire logic onceSel = onceSync_q[1];

  // ============================================================
  // Emulation float state, caught while reset is held
  // A stray select level while running cannot float the bus; only a reset
  // can enter or leave this state.
  logic emuFloat_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      emuFloat_q <= onceSel;
    end
  end

  // ============================================================
  // Yield grant
  // Withdrawal wins over all else, so the grant never outlives the request.
  // In reset there is no cycle to finish, so the grant follows at once;
  // outside reset it waits for the core's cycle to end.
  logic grant_q;
  always_ff @(posedge clk) begin
    if (!yieldReq) begin
      grant_q <= 1'b0;
    end else if (!resetn) begin
      grant_q <= 1'b1;
    end else if (!busCycleActive) begin
      grant_q <= 1'b1;
    end
  end
  // The grant leaves straight from its flop, so it cannot glitch.
  assign busYieldGrant = grant_q;

  // A grant taken in reset must be released before the first access.
  // The synchronised request counts too, so a request still in flight
  // when reset ends holds the core off as well.
  logic holdOff_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      holdOff_q <= grant_q | yieldReq;
    end else if (!yieldReq && !grant_q) begin
      holdOff_q <= 1'b0;
    end
  end
  // Combinational, so the core sees a backoff in the cycle it arrives.
  assign accessAllowed = resetn & ~holdOff_q & ~grant_q & ~backoff
    & ~emuFloat_q;

  // ============================================================
  // Pin state selection, registered so pins settle in one cycle
  // Priority: emulation float, then yield or backoff, then reset, then run.
  // Backoff shares the yield pin set, so it needs no state of its own.
  rhbpc_pkg::rhbpc_mode_t mode;
  always_comb begin
    if (emuFloat_q && resetn) begin
      mode = rhbpc_pkg::RHBPC_FLOAT;
    end else if (grant_q || backoff) begin
      mode = rhbpc_pkg::RHBPC_YIELD;
    end else if (!resetn) begin
      mode = rhbpc_pkg::RHBPC_RESET;
    end else begin
      mode = rhbpc_pkg::RHBPC_RUN;
    end
  end

  // Run state mirrors the core; yield still mirrors request and count pins; reset and float use fixed levels.
  always_ff @(posedge clk) begin
    case (mode)
      // Burst-last is driven active; the direction pins read as receive.
      rhbpc_pkg::RHBPC_RESET: begin
        addrDataOe <= 1'b0;
        ctrlOe <= 1'b1;
        byteLaneEnablesN <= `RHBPC_BE_IDLE;
        addressStrobeN <= 1'b1;
        stallN <= 1'b1;
        dataTransferEnableN <= 1'b1;
        lockN <= 1'b1;
        writeReadSel <= 1'b0;
        transferDirection <= 1'b0;
        burstLastN <= 1'b0;
        busRequestOut <= 1'b0;
        busRequestOe <= 1'b1;
        selectOe <= 1'b0;
        selftestErrorN <= 1'b0;
        dmaAcknowledgeN <= `RHBPC_DACK_IDLE;
        endProcessTcOe <= 4'h0;
        endProcessTcOut <= 4'h0;
      end

      // Request, error, acknowledge and output count pins stay driven.
      rhbpc_pkg::RHBPC_YIELD: begin
        addrDataOe <= 1'b0;
        ctrlOe <= 1'b0;
        byteLaneEnablesN <= `RHBPC_BE_IDLE;
        addressStrobeN <= 1'b1;
        stallN <= 1'b1;
        dataTransferEnableN <= 1'b1;
        lockN <= 1'b1;
        writeReadSel <= 1'b0;
        transferDirection <= 1'b0;
        burstLastN <= 1'b1;
        busRequestOut <= coreBusReq;
        busRequestOe <= 1'b1;
        selectOe <= 1'b0;
        selftestErrorN <= 1'b1;
        dmaAcknowledgeN <= `RHBPC_DACK_IDLE;
        endProcessTcOe <= tcOutputMode;
        endProcessTcOut <= tcOutValue;
      end

      // Strobe levels stay idle here; live bus cycles are outside this block.
      rhbpc_pkg::RHBPC_RUN: begin
        addrDataOe <= 1'b1;
        ctrlOe <= 1'b1;
        byteLaneEnablesN <= `RHBPC_BE_IDLE;
        addressStrobeN <= 1'b1;
        stallN <= 1'b1;
        dataTransferEnableN <= 1'b1;
        lockN <= 1'b1;
        writeReadSel <= 1'b0;
        transferDirection <= 1'b0;
        burstLastN <= 1'b1;
        busRequestOut <= coreBusReq;
        busRequestOe <= 1'b1;
        selectOe <= 1'b1;
        selftestErrorN <= ~selftestFailed;
        dmaAcknowledgeN <= `RHBPC_DACK_IDLE;
        endProcessTcOe <= tcOutputMode;
        endProcessTcOut <= tcOutValue;
      end

      // Every pin group with an enable lets go; the rest rests at idle.
      default: begin
        addrDataOe <= 1'b0;
        ctrlOe <= 1'b0;
        byteLaneEnablesN <= `RHBPC_BE_IDLE;
        addressStrobeN <= 1'b1;
        stallN <= 1'b1;
        dataTransferEnableN <= 1'b1;
        lockN <= 1'b1;
        writeReadSel <= 1'b0;
        transferDirection <= 1'b0;
        burstLastN <= 1'b1;
        busRequestOut <= 1'b0;
        busRequestOe <= 1'b0;
        selectOe <= 1'b0;
        selftestErrorN <= 1'b1;
        dmaAcknowledgeN <= `RHBPC_DACK_IDLE;
        endProcessTcOe <= 4'h0;
        endProcessTcOut <= 4'h0;
      end
    endcase
  end
endmodule : rhbpc_pin_control

/* hw/rhbpc_defs.svh */
// Constants for the reset, hold and backoff bus pin control block.
`ifndef RHBPC_DEFS_SVH
`define RHBPC_DEFS_SVH
// ============================================================
// Timing
`define RHBPC_CLK_PERIOD_NS 5
`define RHBPC_VALID_MAX_PERIODS 32
`define RHBPC_VALID_CYCLES 6'(`RHBPC_VALID_MAX_PERIODS)
`define RHBPC_EMULATION_FLOAT_SELECT_FLOAT_CYCLES 6'(`RHBPC_VALID_MAX_PERIODS)
// ============================================================
// Pin levels
`define RHBPC_BE_IDLE 4'hF
`define RHBPC_DACK_IDLE 4'hF
`endif

/* hw/rhbpc_pkg.sv */
// Types for the reset, hold and backoff bus pin control block.
package rhbpc_pkg;
  typedef enum logic [1:0] {
    RHBPC_RUN = 2'h0,
    RHBPC_RESET = 2'h1,
    RHBPC_YIELD = 2'h2,
    RHBPC_FLOAT = 2'h3
  } rhbpc_mode_t;
endpackage : rhbpc_pkg

/* bench/rhbpc_props.sv */
// Checker for the pin states under reset, yield grant, backoff and float.
`timescale 1ns/1ps
module rhbpc_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic yieldReqPin,
  input wire logic busBackoffPinN,
  input wire logic emulationFloatSelectN,
  input wire logic busCycleActive,
  input wire logic busYieldGrant,
  input wire logic accessAllowed,
  input wire logic addrDataOe,
  input wire logic ctrlOe,
  input wire logic selectOe,
  input wire logic selftestErrorN,
  input wire logic [3:0] byteLaneEnablesN,
  input wire logic [3:0] dmaAcknowledgeN
);
  default clocking cb @(posedge clk); endclocking
  // Reset checks cannot be disabled by reset, so only run ones are.
  grant_float_a: assert property (busYieldGrant |=> !ctrlOe && !addrDataOe
    && selftestErrorN) else $error("pins not floated under grant");
  reset_state_a: assert property (!resetn[*4] ##0 !busYieldGrant[*2]
    |-> !addrDataOe && ctrlOe && byteLaneEnablesN == 4'hF && !selectOe
    && !selftestErrorN && dmaAcknowledgeN == 4'hF) else $error("bad reset");
  grant_reset_a: assert property ($rose(yieldReqPin) && !resetn
    ##1 !resetn[*2] |=> busYieldGrant) else $error("no grant in reset");
  grant_waits_a: assert property ($rose(busYieldGrant)
    |-> !$past(busCycleActive) || !$past(resetn)) else $error("early grant");
  grant_drop_a: assert property ($fell(yieldReqPin) ##1 !yieldReqPin[*2]
    |=> !busYieldGrant) else $error("grant kept");
  access_hold_a: assert property (disable iff (!resetn)
    busYieldGrant |-> !accessAllowed) else $error("access under grant");
  backoff_pins_a: assert property (disable iff (!resetn)
    $fell(busBackoffPinN) ##1 !busBackoffPinN[*2] |=> !ctrlOe && !addrDataOe
    && selftestErrorN && !accessAllowed) else $error("bad backoff pins");
  emu_float_a: assert property ((!emulationFloatSelectN && !resetn)[*4]
    ##1 resetn |=> !ctrlOe && !addrDataOe && !selectOe) else $error("no float");
endmodule : rhbpc_props
bind rhbpc_pin_control rhbpc_props u_props (.*);

/* bench/rhbpc_partner.sv */
// Model of another bus master asking for the bus or forcing a backoff.
`timescale 1ns/1ps
module rhbpc_partner (
  input wire logic clk,
  input wire logic want,
  input wire logic back,
  output logic yieldReqPin = 1'b0,
  output logic busBackoffPinN = 1'b1
);
  logic want_q = 1'b0;
  logic back_q = 1'b0;
  // Sampling on the rising edge keeps it clear of the bench's edge; the pins then change on the falling edge.
  always @(posedge clk) begin
    want_q <= want;
    back_q <= back;
  end
  always @(negedge clk) begin
    yieldReqPin <= want_q;
    busBackoffPinN <= ~back_q;
  end
endmodule : rhbpc_partner

/* bench/tb_top.sv */
// Self-checking bench for the bus pin control block.
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, resetn = 0, want = 0, back = 0, emuN = 1, cyc = 0;
  logic yReq, boffN, grant, acc;
  wire [8:0] st;
  wire [10:0] rs;
  wire stall;
  wire [3:0] tcOe, tcOut;
  logic coreReq = 1'b1, stFail = 1'b1;
  logic [3:0] tcMode = 4'hA, tcVal = 4'h5;
  int err_total = 0, checked = 0;
  initial forever #2.5 clk = ~clk;
  rhbpc_partner u_far (.clk(clk), .want(want), .back(back),
    .yieldReqPin(yReq), .busBackoffPinN(boffN));
  rhbpc_pin_control u_dut (.clk(clk), .resetn(resetn), .yieldReqPin(yReq),
    .busBackoffPinN(boffN), .emulationFloatSelectN(emuN),
    .busCycleActive(cyc), .coreBusReq(coreReq), .selftestFailed(stFail),
    .tcOutputMode(tcMode), .tcOutValue(tcVal), .busYieldGrant(grant),
    .accessAllowed(acc), .addrDataOe(st[8]), .ctrlOe(st[7]),
    .byteLaneEnablesN(rs[10:7]), .addressStrobeN(rs[6]), .stallN(stall),
    .dataTransferEnableN(rs[5]), .lockN(rs[4]), .writeReadSel(rs[3]),
    .transferDirection(rs[2]), .burstLastN(rs[1]), .busRequestOut(rs[0]),
    .busRequestOe(st[5]), .selectOe(st[6]), .selftestErrorN(st[4]),
    .dmaAcknowledgeN(st[3:0]), .endProcessTcOe(tcOe),
    .endProcessTcOut(tcOut));
  task automatic chk(logic [10:0] s, logic [10:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic w(int n);
    repeat (n) @(negedge clk);
  endtask : w
  task automatic complete_run;
    $display("Mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic t_reset_state;
    w(20);
    chk(st, 9'h0AF);
    chk(rs, 11'h7F0);
    chk(stall, 1'b1);
    chk(tcOe, 4'h0);
  endtask : t_reset_state
  task automatic t_hold_in_reset;
    want = 1;
    w(6);
    chk(grant, 1'b1);
    chk(st, 9'h03F);
    chk(rs[0], 1'b1);
    chk({tcOe, tcOut}, 8'hA5);
    resetn = 1;
    w(3);
    chk(acc, 1'b0);
    want = 0;
    w(7);
    chk(grant, 1'b0);
    chk(acc, 1'b1);
    chk(st, 9'h1EF);
  endtask : t_hold_in_reset
  task automatic t_wait_cycle;
    cyc = 1;
    want = 1;
    w(8);
    chk(grant, 1'b0);
    cyc = 0;
    w(3);
    chk(grant, 1'b1);
    want = 0;
    w(7);
  endtask : t_wait_cycle
  task automatic t_backoff;
    back = 1;
    coreReq = 1'b0;
    w(6);
    chk(st[8:4], 5'h03);
    chk(acc, 1'b0);
    chk(rs[0], 1'b0);
    chk({tcOe, tcOut}, 8'hA5);
    back = 0;
    w(6);
    chk(acc, 1'b1);
  endtask : t_backoff
  task automatic t_float;
    resetn = 0;
    emuN = 0;
    w(32);
    resetn = 1;
    w(2);
    chk(st[8:5], 4'h0);
    chk(tcOe, 4'h0);
    resetn = 0;
    emuN = 1;
    w(5);
  endtask : t_float
  initial begin
    #20000;
    err_total++;
    complete_run();
  end
  initial begin
    t_reset_state();
    t_hold_in_reset();
    t_wait_cycle();
    t_backoff();
    t_float();
    complete_run();
  end
endmodule : tb_top
